// File: rtl/drive_aux.v
// pulse scaling, pulse status output, precise stop, brake latch and trip restart
// assumes pclk at 25 MHz; pin inputs are asynchronous, drive-core inputs are on pclk
//
// Design decisions made here: the register offsets and the APB slave port.
`include "drive_aux_defines.vh"

// ----------------------------------------
// pulse input frequency scaler
// ----------------------------------------
module pulse_scaler (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        pin_s,
  input  wire        gate,
  input  wire        enable,
  input  wire [13:0] max_hz,
  input  wire [31:0] full,
  output reg  [31:0] value_r
);
  reg         pin_d_r;
  reg  [15:0] cnt_r;
  wire [31:0] hz = {16'h0000, cnt_r} * `GATE_MUL;
  wire [63:0] prod = hz * full;
  wire [63:0] quo  = prod / {50'h0, max_hz};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 1'b0;
      cnt_r   <= 16'h0000;
      value_r <= 32'h00000000;
    end else begin
      pin_d_r <= pin_s;
      if (gate) begin
        cnt_r <= {15'h0000, pin_s & ~pin_d_r};
        if (!enable)
          value_r <= 32'h00000000;
        else if (hz >= {18'h00000, max_hz})
          value_r <= full;
        else
          value_r <= quo[31:0];
      end else if (pin_s & ~pin_d_r)
        cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module drive_aux #(
  parameter MS_CYCLES = 25000
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        pulse33_pin,
  input  wire        pulse29_pin,
  input  wire        run_pin,
  input  wire        reset_key_pin,
  input  wire        reset_din_pin,
  input  wire        line_ok_pin,
  input  wire        serial_reset,
  input  wire        fault_in,
  input  wire        fault_line,
  input  wire        at_current_limit,
  input  wire        zero_speed,
  input  wire [31:0] ref_value,
  input  wire [31:0] ref_min,
  input  wire [31:0] ref_max,
  input  wire [31:0] fb_value,
  input  wire [31:0] feedback_lower_bound,
  input  wire [31:0] feedback_upper_bound,
  input  wire [31:0] out_freq,
  input  wire [31:0] freq_max,
  input  wire [31:0] out_current,
  input  wire [31:0] inverter_rated_current,
  input  wire [31:0] out_power,
  input  wire [31:0] motor_power,
  input  wire [31:0] heatsink_temp,
  output wire [31:0] pulse33_value,
  output wire [31:0] pulse29_value,
  output reg         status_out,
  output reg         stop_out,
  output reg         precise_ramp,
  output reg  [2:0]  brake_mode,
  output reg         trip_out,
  output reg         restart_out
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
    end else begin
      s1_r <= {line_ok_pin, reset_din_pin, reset_key_pin, run_pin, pulse29_pin, pulse33_pin};
      s2_r <= s1_r;
    end
  end
  wire p33_s  = s2_r[0];
  wire p29_s  = s2_r[1];
  wire run_s  = s2_r[2];
  wire man_s  = s2_r[3] | s2_r[4];
  wire line_s = s2_r[5];

  // ----------------------------------------
  // registers and APB
  // ----------------------------------------
  reg [31:0] cfg_r;
  reg [13:0] p33max_r;
  reg [13:0] p29max_r;
  reg [13:0] poutmax_r;
  reg [19:0] count_r;
  reg [6:0]  sysdly_r;
  reg [3:0]  rsttime_r;
  reg [5:0]  tripdly_r;
  reg [15:0] ctrlword_r;
  reg [15:0] rampms_r;
  wire [1:0] role33    = cfg_r[1:0];
  wire [1:0] role29    = cfg_r[3:2];
  wire [4:0] src_sel   = cfg_r[8:4];
  wire [2:0] stop_mode = cfg_r[11:9];
  wire [2:0] brake_sel = cfg_r[14:12];
  wire [3:0] rst_mode  = cfg_r[18:15];
  wire [31:0] status_w;
  reg  [31:0] rd;
  reg         hit;
  always @* begin
    rd  = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `A_CFG:      rd = cfg_r;
      `A_P33MAX:   rd = {18'h00000, p33max_r};
      `A_P29MAX:   rd = {18'h00000, p29max_r};
      `A_POUTMAX:  rd = {18'h00000, poutmax_r};
      `A_COUNT:    rd = {12'h000, count_r};
      `A_SYSDLY:   rd = {25'h0000000, sysdly_r};
      `A_RSTTIME:  rd = {28'h0000000, rsttime_r};
      `A_TRIPDLY:  rd = {26'h0000000, tripdly_r};
      `A_STATUS:   rd = status_w;
      `A_CTRLWORD: rd = {16'h0000, ctrlword_r};
      `A_RAMPMS:   rd = {16'h0000, rampms_r};
      default:     hit = 1'b0;
    endcase
  end
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      cfg_r      <= 32'h00000000;
      p33max_r   <= `RV_PMAX;
      p29max_r   <= `RV_PMAX;
      poutmax_r  <= `RV_PMAX;
      count_r    <= `RV_COUNT;
      sysdly_r   <= `RV_SYSDLY;
      rsttime_r  <= `RV_RSTTIME;
      tripdly_r  <= `RV_TRIPDLY;
      ctrlword_r <= 16'h0000;
      rampms_r   <= `RV_RAMPMS;
    end else begin
      // answer prepared in setup so the access phase lasts one cycle
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable)
        prdata <= (hit & ~pwrite) ? rd : 32'h00000000;
      if (wr) begin
        case (paddr)
          `A_CFG:      cfg_r      <= {13'h0000, pwdata[18:0]};
          `A_P33MAX:   p33max_r   <= pwdata[13:0];
          `A_P29MAX:   p29max_r   <= pwdata[13:0];
          `A_POUTMAX:  poutmax_r  <= pwdata[13:0];
          `A_COUNT:    count_r    <= pwdata[19:0];
          `A_SYSDLY:   sysdly_r   <= pwdata[6:0];
          `A_RSTTIME:  rsttime_r  <= pwdata[3:0];
          `A_TRIPDLY:  tripdly_r  <= pwdata[5:0];
          `A_CTRLWORD: ctrlword_r <= pwdata[15:0];
          `A_RAMPMS:   rampms_r   <= pwdata[15:0];
          default:     ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // time base: ms tick, second tick, gate
  // ----------------------------------------
  reg [15:0] div_r;
  reg [9:0]  ms_r;
  reg [6:0]  gms_r;
  wire ms_tick  = (div_r == MS_CYCLES[15:0] - 16'h0001);
  wire s_tick   = ms_tick & (ms_r == `MS_PER_S - 10'h001);
  wire gate     = ms_tick & (gms_r == `GATE_MS - 7'h01);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
      ms_r  <= 10'h000;
      gms_r <= 7'h00;
    end else begin
      div_r <= ms_tick ? 16'h0000 : div_r + 16'h0001;
      if (ms_tick) begin
        ms_r  <= s_tick ? 10'h000 : ms_r + 10'h001;
        gms_r <= gate ? 7'h00 : gms_r + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // pulse inputs
  // ----------------------------------------
  pulse_scaler u_p33 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_s   (p33_s),
    .gate    (gate),
    .enable  (role33 == `ROLE_REF || role33 == `ROLE_FB),
    .max_hz  (p33max_r),
    .full    ((role33 == `ROLE_FB) ? feedback_upper_bound : ref_max),
    .value_r (pulse33_value)
  );
  pulse_scaler u_p29 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_s   (p29_s),
    .gate    (gate),
    .enable  (role29 == `ROLE_REF || role29 == `ROLE_FB),
    .max_hz  (p29max_r),
    .full    ((role29 == `ROLE_FB) ? feedback_upper_bound : ref_max),
    .value_r (pulse29_value)
  );

  // ----------------------------------------
  // pulse status output
  // ----------------------------------------
  reg [31:0] q;
  reg [31:0] lo;
  reg [31:0] hi;
  always @* begin
    q  = 32'h00000000;
    lo = 32'h00000000;
    hi = 32'h00000001;
    case (src_sel)
      `SRC_REF:  begin q = ref_value; lo = ref_min; hi = ref_max; end
      `SRC_FB:   begin q = fb_value; lo = feedback_lower_bound;
                       hi = feedback_upper_bound; end
      `SRC_FREQ: begin q = out_freq; hi = freq_max; end
      `SRC_CUR:  begin q = out_current; hi = inverter_rated_current; end
      `SRC_PWR:  begin q = out_power; hi = motor_power; end
      `SRC_TEMP: begin q = heatsink_temp; lo = `TEMP_LO; hi = `TEMP_HI; end
      default:   ;
    endcase
  end
  wire [31:0] num  = (q <= lo) ? 32'h00000000 : (q >= hi) ? hi - lo : q - lo;
  wire [31:0] den  = (hi > lo) ? hi - lo : 32'h00000001;
  wire [63:0] tprd = num * {18'h00000, poutmax_r};
  wire [63:0] tquo = tprd / {32'h00000000, den};
  wire [31:0] tgt  = tquo[31:0];
  reg  [31:0] acc_r;
  reg         wave_r;
  wire [31:0] acc_n = acc_r + {tgt[30:0], 1'b0};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r      <= 32'h00000000;
      wave_r     <= 1'b0;
      status_out <= 1'b0;
    end else begin
      // phase accumulator: two toggles per output period
      if (acc_n >= `CLK_HZ) begin
        acc_r  <= acc_n - `CLK_HZ;
        wave_r <= ~wave_r;
      end else
        acc_r <= acc_n;
      if (src_sel == `SRC_CW)
        status_out <= ctrlword_r[`CW_BIT];
      else
        status_out <= wave_r;
    end
  end

  // ----------------------------------------
  // precise stop
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_DLY  = 4'b0100;
  localparam [3:0] ST_RAMP = 4'b1000;
  reg  [3:0]  st_r;
  reg         run_d_r;
  reg         p33_d_r;
  reg  [19:0] remain_r;
  reg  [19:0] over_r;
  reg  [19:0] carry_r;
  reg  [15:0] dly_r;
  wire        cnt_edge = p33_s & ~p33_d_r;
  wire        cnt_mode = (stop_mode == `STOP_CRST) | (stop_mode == `STOP_CKEEP) |
                         (stop_mode == `STOP_SCRST) | (stop_mode == `STOP_SCKP);
  wire        sc_mode  = (stop_mode == `STOP_SC) | (stop_mode == `STOP_SCRST) |
                         (stop_mode == `STOP_SCKP);
  wire        keep_mode = (stop_mode == `STOP_CKEEP) | (stop_mode == `STOP_SCKP);
  wire        stop_evt = (~run_s & run_d_r) | (cnt_mode & (remain_r == 20'h00000));
  // lag below full speed is half the ramp fraction, less the fixed system delay
  wire [31:0] fdelta = (out_freq >= freq_max) ? 32'h00000000 : freq_max - out_freq;
  wire [63:0] dprod  = fdelta * {16'h0000, rampms_r};
  wire [63:0] dquo   = dprod / {32'h00000000, freq_max[30:0], 1'b1};
  wire [31:0] dfull  = dquo[31:0];
  wire [31:0] dcomp  = (dfull > {25'h0000000, sysdly_r}) ?
                       dfull - {25'h0000000, sysdly_r} : 32'h00000000;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= ST_IDLE;
      run_d_r      <= 1'b0;
      p33_d_r      <= 1'b0;
      remain_r     <= 20'h00000;
      over_r       <= 20'h00000;
      carry_r      <= 20'h00000;
      dly_r        <= 16'h0000;
      stop_out     <= 1'b1;
      precise_ramp <= 1'b0;
    end else begin
      run_d_r <= run_s;
      p33_d_r <= p33_s;
      case (st_r)
        ST_IDLE: begin
          stop_out <= 1'b1;
          if (run_s & ~run_d_r) begin
            remain_r <= (count_r > carry_r) ? count_r - carry_r : 20'h00000;
            over_r   <= 20'h00000;
            stop_out <= 1'b0;
            st_r     <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_edge && remain_r != 20'h00000)
            remain_r <= remain_r - 20'h00001;
          if (stop_evt) begin
            precise_ramp <= (stop_mode == `STOP_RAMP);
            if (sc_mode && dcomp != 32'h00000000) begin
              dly_r <= dcomp[15:0];
              st_r  <= ST_DLY;
            end else begin
              stop_out <= 1'b1;
              st_r     <= ST_RAMP;
            end
          end
        end
        ST_DLY: begin
          if (ms_tick)
            dly_r <= dly_r - 16'h0001;
          if (dly_r == 16'h0000) begin
            stop_out <= 1'b1;
            st_r     <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          stop_out <= 1'b1;
          if (cnt_edge)
            over_r <= over_r + 20'h00001;
          if (zero_speed) begin
            carry_r      <= keep_mode ? over_r : 20'h00000;
            precise_ramp <= 1'b0;
            st_r         <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // brake latch: taken only when line power returns
  // ----------------------------------------
  reg line_d_r;
  wire line_up = line_s & ~line_d_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_d_r   <= 1'b0;
      brake_mode <= 3'h0;
    end else begin
      line_d_r <= line_s;
      if (line_up)
        brake_mode <= brake_sel;
    end
  end

  // ----------------------------------------
  // trip and restart
  // ----------------------------------------
  reg  [5:0] lim_s_r;
  reg  [3:0] wait_r;
  reg  [3:0] tries_r;
  reg        line_flt_r;
  wire       auto_mode = (rst_mode != `RST_MANUAL) & (rst_mode != `RST_PWRUP);
  wire       oc_trip   = (tripdly_r != `TRIP_OFF) & at_current_limit &
                         (lim_s_r >= tripdly_r);
  wire       trip_set  = fault_in | oc_trip;
  wire       man_clr   = man_s | serial_reset;
  wire       auto_clr  = trip_out & auto_mode & (tries_r < rst_mode) &
                         (wait_r >= rsttime_r);
  wire       pwr_clr   = trip_out & (rst_mode == `RST_PWRUP) & line_flt_r & line_up;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_s_r     <= 6'h00;
      wait_r      <= 4'h0;
      tries_r     <= 4'h0;
      line_flt_r  <= 1'b0;
      trip_out    <= 1'b0;
      restart_out <= 1'b0;
    end else begin
      restart_out <= 1'b0;
      if (!at_current_limit)
        lim_s_r <= 6'h00;
      else if (s_tick && lim_s_r != 6'h3F)
        lim_s_r <= lim_s_r + 6'h01;
      if (!trip_out)
        wait_r <= 4'h0;
      else if (s_tick && wait_r != 4'hF)
        wait_r <= wait_r + 4'h1;
      // a new trip in the clearing cycle wins
      if (trip_set) begin
        trip_out <= 1'b1;
        if (!trip_out)
          line_flt_r <= fault_line;
      end else if (man_clr) begin
        trip_out <= 1'b0;
        tries_r  <= 4'h0;
      end else if (auto_clr) begin
        trip_out    <= 1'b0;
        restart_out <= 1'b1;
        tries_r     <= tries_r + 4'h1;
      end else if (pwr_clr) begin
        trip_out   <= 1'b0;
        line_flt_r <= 1'b0;
      end
    end
  end

  assign status_w = {21'h000000, tries_r, trip_out, line_flt_r, stop_out, st_r};
endmodule

// File: rtl/drive_aux_defines.vh
// constants for the drive auxiliary control block
// assumes a 25 MHz pclk and byte addresses on an APB bus
`ifndef DRIVE_AUX_DEFINES_VH
`define DRIVE_AUX_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define A_CFG      8'h00
`define A_P33MAX   8'h04
`define A_P29MAX   8'h08
`define A_POUTMAX  8'h0C
`define A_COUNT    8'h10
`define A_SYSDLY   8'h14
`define A_RSTTIME  8'h18
`define A_TRIPDLY  8'h1C
`define A_STATUS   8'h20
`define A_CTRLWORD 8'h24
`define A_RAMPMS   8'h28
// ----------------------------------------
// reset values
// ----------------------------------------
`define RV_PMAX    14'h1388
`define RV_COUNT   20'h186A0
`define RV_SYSDLY  7'h0A
`define RV_RSTTIME 4'h5
`define RV_TRIPDLY 6'h3D
`define RV_RAMPMS  16'h03E8
// ----------------------------------------
// codes
// ----------------------------------------
`define ROLE_REF   2'h1
`define ROLE_FB    2'h2
`define SRC_CW     5'h15
`define SRC_REF    5'h1A
`define SRC_FB     5'h1B
`define SRC_FREQ   5'h1C
`define SRC_CUR    5'h1D
`define SRC_PWR    5'h1E
`define SRC_TEMP   5'h1F
`define STOP_RAMP  3'h0
`define STOP_CRST  3'h1
`define STOP_CKEEP 3'h2
`define STOP_SC    3'h3
`define STOP_SCRST 3'h4
`define STOP_SCKP  3'h5
`define RST_MANUAL 4'h0
`define RST_PWRUP  4'hB
`define TRIP_OFF   6'h3D
`define TEMP_LO    32'h14
`define TEMP_HI    32'h64
`define CW_BIT     12
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ     32'h017D7840
`define MS_PER_S   10'h3E8
`define GATE_MS    7'h64
`define GATE_MUL   32'hA
`endif

// File: testbench/drive_aux_properties.sv
// port-level timing checks for the drive auxiliary block
// assumes it is bound into every drive_aux instance, one pclk domain
module drive_aux_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        run_pin,
  input wire logic        line_ok_pin,
  input wire logic        serial_reset,
  input wire logic        fault_in,
  input wire logic        at_current_limit,
  input wire logic        stop_out,
  input wire logic        precise_ramp,
  input wire logic [2:0]  brake_mode,
  input wire logic        trip_out,
  input wire logic        restart_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  chk_apb_ready: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_bad_addr: assert property (s_setup ##0 paddr > 8'h28 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // ----------------------------------------
  // stop, brake, trip
  // ----------------------------------------
  chk_start_edge: assert property ($fell(stop_out) |-> $past(run_pin, 2))
    else $error("run began without start edge");
  chk_ramp_stop: assert property (precise_ramp |-> stop_out)
    else $error("precise ramp while running");
  // pin sync takes a few edges, so look well before the change
  chk_brake_hold: assert property ($changed(brake_mode) |-> line_ok_pin && !$past(line_ok_pin, 6))
    else $error("brake mode changed without power return");
  chk_trip_set: assert property (fault_in |=> trip_out)
    else $error("fault did not trip");
  chk_manual_clear: assert property (trip_out && serial_reset && !fault_in && !at_current_limit
    |=> !trip_out)
    else $error("manual reset ignored");
  chk_restart_src: assert property (restart_out |-> $past(trip_out))
    else $error("restart without trip");
  chk_restart_pulse: assert property (restart_out |=> !restart_out)
    else $error("restart pulse too long");
endmodule

bind drive_aux drive_aux_properties chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .run_pin, .line_ok_pin, .serial_reset, .fault_in, .at_current_limit,
  .stop_out, .precise_ramp, .brake_mode, .trip_out, .restart_out);

// File: testbench/pulse_source.sv
// pulse sensor model: square train, half period in pclk cycles
// assumes pclk at 25 MHz; line rests low while disabled
module pulse_source #(
  parameter int MIN_HALF = 185
) (
  input  wire logic        pclk,
  input  wire logic        en,
  input  wire logic [15:0] half,
  output logic             pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r = 16'h0;
  logic [15:0] lim;
  // never faster than the counter can register
  assign lim = (half < 16'(MIN_HALF)) ? 16'(MIN_HALF) : half;
  initial pulse = 1'b0;
  always @(posedge pclk) begin
    if (!en) begin
      cnt_r <= 16'h0;
      pulse <= 1'b0;
    end else if (cnt_r >= lim - 16'h1) begin
      cnt_r <= 16'h0;
      pulse <= ~pulse;
    end else
      cnt_r <= cnt_r + 16'h1;
  end
endmodule

// File: testbench/testbench.sv
// self-checking bench for drive_aux over APB
// assumes drive_aux, its checker and pulse_source are compiled before
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 20;
  localparam int GATE = MS * 100;
  localparam int HALF = 200;
  localparam logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h28};
  localparam logic [31:0] RV [9] = '{32'h0, 32'h1388, 32'h1388, 32'h1388, 32'h186A0, 32'hA,
    32'h5, 32'h3D, 32'h3E8};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        run_pin = 1'b0;
  logic        line_ok_pin = 1'b1;
  logic        serial_reset = 1'b0;
  logic        fault_in = 1'b0;
  logic        zero_speed = 1'b0;
  logic        pen = 1'b0;
  logic        at_lim = 1'b0;
  logic        se;
  logic [31:0] q [0:12];
  logic [31:0] prdata, rd, r, pulse33_value, pulse29_value;
  logic        pready, pslverr, pulse33_pin, pulse29_pin, status_out, stop_out;
  logic        precise_ramp, trip_out, restart_out;
  logic [2:0]  brake_mode;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          edges = 0;
  int          i;

  drive_aux #(.MS_CYCLES(MS)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pulse33_pin, .pulse29_pin, .run_pin, .reset_key_pin(1'b0),
    .reset_din_pin(1'b0), .line_ok_pin, .serial_reset, .fault_in, .fault_line(1'b0),
    .at_current_limit(at_lim), .zero_speed, .ref_value(q[0]), .ref_min(q[1]), .ref_max(q[2]),
    .fb_value(q[3]), .feedback_lower_bound(q[4]), .feedback_upper_bound(q[5]),
    .out_freq(q[6]), .freq_max(q[7]), .out_current(q[8]), .inverter_rated_current(q[9]),
    .out_power(q[10]), .motor_power(q[11]), .heatsink_temp(q[12]), .pulse33_value,
    .pulse29_value, .status_out, .stop_out, .precise_ramp, .brake_mode, .trip_out,
    .restart_out);
  pulse_source src33 (.pclk, .en(pen), .half(16'(HALF)), .pulse(pulse33_pin));
  pulse_source src29 (.pclk, .en(pen), .half(16'(HALF)), .pulse(pulse29_pin));

  initial forever #20 pclk = ~pclk;
  always @(posedge pulse33_pin) edges++;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    chk((got + tol >= exp && got <= exp + tol) ? exp : got, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // count rising edges of the status output over n cycles
  task automatic waves(input int n, output int e);
    logic p;
    e = 0;
    p = status_out;
    repeat (n) begin
      @(posedge pclk);
      if (status_out && !p) e++;
      p = status_out;
    end
  endtask
  // 5 pulses per gate, ten hertz per count
  function automatic logic [31:0] scaled(input logic [31:0] full, input logic [31:0] mx);
    logic [63:0] v;
    v = 64'(full) * 64'(GATE / (2 * HALF) * 10) / 64'(mx);
    return (v > 64'(full)) ? full : v[31:0];
  endfunction
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(78505);
    foreach (q[k]) q[k] <= ($urandom & 32'hFFFF) | 32'h1;
    ticks(6);
    presetn <= 1'b1;
    for (i = 0; i < 9; i++) rchk(RA[i], RV[i]);
    rchk(8'h2C, 32'h0);
    chk(se, 32'h1);
    r = $urandom & 32'hFFFFF;
    apb(1'b1, 8'h10, r);
    rchk(8'h10, r);
    pen <= 1'b1;
    ticks(2 * GATE + 10);
    chk(pulse33_value, 32'h0);
    chk(pulse29_value, 32'h0);
    r = 32'd100 + $urandom % 200;
    apb(1'b1, 8'h04, r);
    apb(1'b1, 8'h00, 32'h9);
    ticks(2 * GATE + 10);
    near(pulse33_value, scaled(q[2], r), q[2] * 10 / r + 1);
    near(pulse29_value, scaled(q[5], 32'h1388), q[5] / 500 + 1);
    // counter stop with reset, three pulses
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h00, 32'h209);
    @(posedge pulse33_pin);
    @(posedge pclk);
    run_pin <= 1'b1; // plain start level, never pulse start
    edges = 0;
    ticks(8);
    chk(stop_out, 32'h0);
    for (i = 0; i < 3000 && stop_out !== 1'b1; i++) @(posedge pclk);
    chk(edges, 32'h3);
    zero_speed <= 1'b1;
    run_pin <= 1'b0;
    ticks(4);
    zero_speed <= 1'b0;
    apb(1'b1, 8'h00, 32'h9);
    run_pin <= 1'b1;
    ticks(10);
    run_pin <= 1'b0;
    ticks(8);
    chk(precise_ramp, 32'h1);
    chk(stop_out, 32'h1);
    zero_speed <= 1'b1;
    ticks(4);
    zero_speed <= 1'b0;
    r = ($urandom & 32'hEFFF) | 32'h1000;
    apb(1'b1, 8'h00, 32'h150);
    apb(1'b1, 8'h24, r);
    ticks(4);
    chk(status_out, 32'h1);
    apb(1'b1, 8'h24, r & 32'hEFFF);
    ticks(4);
    chk(status_out, 32'h0);
    // heatsink source, 10000 Hz full scale: four periods in 10000 cycles at 25 MHz
    apb(1'b1, 8'h0C, 32'h2710);
    apb(1'b1, 8'h00, 32'h1F0);
    q[12] <= 32'h64;
    waves(10000, i);
    near(i, 32'h4, 32'h1);
    q[12] <= 32'hA;
    ticks(4);
    waves(5000, i);
    chk(i, 32'h0);
    apb(1'b1, 8'h00, 32'h4000);
    ticks(4);
    chk(brake_mode, 32'h0);
    line_ok_pin <= 1'b0;
    ticks(10);
    line_ok_pin <= 1'b1;
    ticks(8);
    chk(brake_mode, 32'h4);
    fault_in <= 1'b1;
    ticks(1);
    fault_in <= 1'b0;
    ticks(50);
    chk(trip_out, 32'h1);
    serial_reset <= 1'b1;
    ticks(1);
    serial_reset <= 1'b0;
    ticks(2);
    chk(trip_out, 32'h0);
    // one automatic attempt, then the trip must stick
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h00, 32'h8000);
    fault_in <= 1'b1;
    ticks(1);
    fault_in <= 1'b0;
    for (i = 0; i < 25000 && restart_out !== 1'b1; i++) @(posedge pclk);
    chk(restart_out, 32'h1);
    chk(trip_out, 32'h0);
    fault_in <= 1'b1;
    ticks(1);
    fault_in <= 1'b0;
    ticks(2000);
    chk(trip_out, 32'h1);
    // current at the limit trips within one second, at the next second tick, never while the delay is off
    apb(1'b1, 8'h1C, 32'h1);
    serial_reset <= 1'b1;
    ticks(1);
    serial_reset <= 1'b0;
    at_lim <= 1'b1;
    ticks(2);
    chk(trip_out, 32'h0);
    for (i = 0; i < 21000 && trip_out !== 1'b1; i++) @(posedge pclk);
    chk(trip_out, 32'h1);
    apb(1'b1, 8'h1C, 32'h3D);
    serial_reset <= 1'b1;
    ticks(1);
    serial_reset <= 1'b0;
    ticks(21000);
    chk(trip_out, 32'h0);
    wrap_up();
  end
endmodule
